//--- tcit_defines.vh
`ifndef TCIT_DEFINES_VH
`define TCIT_DEFINES_VH
`define TCIT_A_CMP0H   4'h0
`define TCIT_A_CMP0L   4'h1
`define TCIT_A_CMP1H   4'h2
`define TCIT_A_CMP1L   4'h3
`define TCIT_A_IRQH    4'h4
`define TCIT_A_IRQL    4'h5
`define TCIT_A_START   4'h6
`define TCIT_A_STOP    4'h7
`define TCIT_A_MODE0   4'h8
`define TCIT_A_MODE1   4'h9
`define TCIT_A_STAT    4'ha
`define TCIT_A_MASK    4'hb
`define TCIT_A_OUT     4'hc
`define TCIT_A_CNT0H   4'hd
`define TCIT_A_CNT0L   4'he
`define TCIT_A_CNT1L   4'hf
`define TCIT_M_INTERVAL 3'h0
`define TCIT_M_CAPTURE  3'h2
`define TCIT_M_EVENT    3'h3
`define TCIT_M_ONECNT   3'h4
`define TCIT_M_CAPONE   3'h6
`define TCIT_BIT_IRQ0   7
`define TCIT_BIT_IRQ1   0
`define TCIT_CMP_RESET  16'hffff
`endif

//--- tcit_timer.v
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "tcit_defines.vh"
module tcit_timer #(
  parameter CW = 16
) (
  // clock, reset, enable
  input  wire       CLOCK,
  input  wire       RST_N,
  input  wire       CLK_EN,
  // count clock enable and capture input
  input  wire       COUNT_TICK,
  input  wire [1:0] CAPTURE_IN,
  // register port
  input  wire [3:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  // outputs
  output reg  [1:0] TIMER_OUT,
  output reg        IRQ
);
  reg  [CW-1:0] cmp_q [0:1];
  reg  [CW-1:0] cnt_q [0:1];
  reg  [3:0]    mode_q [0:1];
  reg  [1:0]    en_q;
  reg  [1:0]    run_q;
  reg  [1:0]    flag_q;
  reg  [1:0]    stat_q;
  reg  [1:0]    mask_q;
  reg  [1:0]    cap_q;
  reg  [CW-1:0] capv_q [0:1];
  reg  [1:0]    bad_q;
  reg  [7:0]    rdata_d;
  integer       i;

  function valid_mode;
    input [3:0] m;
    begin
      case (m[3:1])
        `TCIT_M_INTERVAL, `TCIT_M_CAPTURE, `TCIT_M_ONECNT: valid_mode = 1'b1;
        `TCIT_M_EVENT, `TCIT_M_CAPONE: valid_mode = ~m[0];
        default: valid_mode = 1'b0;
      endcase
    end
  endfunction

  function counts_up;
    input [3:0] m;
    begin
      counts_up = (m[3:1] == `TCIT_M_CAPTURE) || (m[3:1] == `TCIT_M_CAPONE);
    end
  endfunction

  wire [1:0] start_w = (WR && ADDR == `TCIT_A_START) ? WDATA[1:0] : 2'h0;
  wire [1:0] stop_w  = (WR && ADDR == `TCIT_A_STOP)  ? WDATA[1:0] : 2'h0;

  always @* begin
    rdata_d = 8'h00;
    case (ADDR)
      `TCIT_A_CMP0H: rdata_d = cmp_q[0][15:8];
      `TCIT_A_CMP0L: rdata_d = cmp_q[0][7:0];
      `TCIT_A_CMP1H: rdata_d = cmp_q[1][15:8];
      `TCIT_A_CMP1L: rdata_d = cmp_q[1][7:0];
      `TCIT_A_IRQH:  rdata_d[`TCIT_BIT_IRQ1] = flag_q[1];
      `TCIT_A_IRQL:  rdata_d[`TCIT_BIT_IRQ0] = flag_q[0];
      `TCIT_A_START: rdata_d = {6'h00, en_q};
      `TCIT_A_STOP:  rdata_d = 8'h00;
      `TCIT_A_MODE0: rdata_d = {4'h0, mode_q[0]};
      `TCIT_A_MODE1: rdata_d = {4'h0, mode_q[1]};
      `TCIT_A_STAT:  rdata_d = {4'h0, bad_q, stat_q};
      `TCIT_A_MASK:  rdata_d = {6'h00, mask_q};
      `TCIT_A_OUT:   rdata_d = {4'h0, run_q, TIMER_OUT};
      `TCIT_A_CNT0H: rdata_d = (mode_q[0][3:1] == `TCIT_M_CAPTURE ||
                                mode_q[0][3:1] == `TCIT_M_CAPONE) ?
                               capv_q[0][15:8] : cnt_q[0][15:8];
      `TCIT_A_CNT0L: rdata_d = cnt_q[0][7:0];
      `TCIT_A_CNT1L: rdata_d = cnt_q[1][7:0];
      default:       rdata_d = 8'h00;
    endcase
  end

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      for (i = 0; i < 2; i = i + 1) begin
        cmp_q[i]  <= `TCIT_CMP_RESET;
        cnt_q[i]  <= {CW{1'b0}};
        capv_q[i] <= {CW{1'b0}};
        mode_q[i] <= 4'h0;
      end
      en_q      <= 2'h0;
      run_q     <= 2'h0;
      flag_q    <= 2'h0;
      stat_q    <= 2'h0;
      mask_q    <= 2'h0;
      cap_q     <= 2'h0;
      bad_q     <= 2'h0;
      RDATA     <= 8'h00;
      TIMER_OUT <= 2'h0;
      IRQ       <= 1'b0;
    end else if (CLK_EN) begin
      RDATA <= RD ? rdata_d : 8'h00;
      if (WR) begin
        case (ADDR)
          `TCIT_A_CMP0H: cmp_q[0][15:8] <= WDATA;
          `TCIT_A_CMP0L: cmp_q[0][7:0]  <= WDATA;
          `TCIT_A_CMP1H: cmp_q[1][15:8] <= WDATA;
          `TCIT_A_CMP1L: cmp_q[1][7:0]  <= WDATA;
          `TCIT_A_MODE0: mode_q[0] <= WDATA[3:0];
          `TCIT_A_MODE1: mode_q[1] <= WDATA[3:0];
          `TCIT_A_MASK:  mask_q    <= WDATA[1:0];
          default: ;
        endcase
      end
      for (i = 0; i < 2; i = i + 1) begin : chan
        reg ev;
        reg st;
        reg [3:0] m;
        ev = 1'b0;
        m  = mode_q[i];
        st = start_w[i];
        bad_q[i] <= ~valid_mode(m);
        // start wins over a same-cycle stop
        if (st)
          en_q[i] <= 1'b1;
        else if (stop_w[i])
          en_q[i] <= 1'b0;
        if (stop_w[i] && !st)
          run_q[i] <= 1'b0;
        if (st && valid_mode(m)) begin
          // one-count retrigger only with option set
          if (m[3:1] == `TCIT_M_ONECNT && run_q[i] && !m[0]) begin
            ev = 1'b0;
          end else begin
            run_q[i] <= 1'b1;
            cnt_q[i] <= counts_up(m) ? {CW{1'b0}} : cmp_q[i];
            if (m[3:1] == `TCIT_M_ONECNT && run_q[i] && m[0])
              ev = 1'b1;
            else if (m[0] && (m[3:1] == `TCIT_M_INTERVAL ||
                              m[3:1] == `TCIT_M_CAPTURE)) begin
              ev = 1'b1;
              TIMER_OUT[i] <= ~TIMER_OUT[i];
            end
            // otherwise no start interrupt, output unchanged
          end
        end else if (run_q[i] && en_q[i] && COUNT_TICK) begin
          if (counts_up(m)) begin
            cnt_q[i] <= cnt_q[i] + 1'b1;
            if (CAPTURE_IN[i] && !cap_q[i]) begin
              capv_q[i] <= cnt_q[i];
              ev = 1'b1;
              if (m[3:1] == `TCIT_M_CAPONE)
                run_q[i] <= 1'b0;
              else
                cnt_q[i] <= {CW{1'b0}};
            end
          end else if (cnt_q[i] == {CW{1'b0}}) begin
            ev = 1'b1;
            if (m[3:1] == `TCIT_M_ONECNT)
              run_q[i] <= 1'b0;
            else begin
              cnt_q[i] <= cmp_q[i];
              TIMER_OUT[i] <= ~TIMER_OUT[i];
            end
          end else begin
            cnt_q[i] <= cnt_q[i] - 1'b1;
          end
        end
        if (COUNT_TICK)
          cap_q[i] <= CAPTURE_IN[i];
        if (ev)
          flag_q[i] <= 1'b1;
        else if (WR && i == 0 && ADDR == `TCIT_A_IRQL &&
                 !WDATA[`TCIT_BIT_IRQ0])
          flag_q[i] <= 1'b0;
        else if (WR && i == 1 && ADDR == `TCIT_A_IRQH &&
                 !WDATA[`TCIT_BIT_IRQ1])
          flag_q[i] <= 1'b0;
        if (ev)
          stat_q[i] <= 1'b1;
        else if (RD && ADDR == `TCIT_A_STAT)
          stat_q[i] <= 1'b0;
      end
      IRQ <= |(stat_q & mask_q);
    end
  end
endmodule

//--- tcit_timer_monitor.sv
`timescale 1ns/10ps
module tcit_monitor (
  // clock and reset
  input wire       CLOCK,
  input wire       RST_N,
  input wire       CLK_EN,
  // stimulus
  input wire       COUNT_TICK,
  input wire [3:0] ADDR,
  input wire [7:0] WDATA,
  input wire       WR,
  input wire       RD,
  // results
  input wire [7:0] RDATA,
  input wire [1:0] TIMER_OUT,
  input wire       IRQ
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  wire e = CLK_EN;
  wire w = e && WR;
  wire r = e && RD;
  rdata_idle_a: assert property (e && !RD |=> RDATA == 8'h00)
    else $error("read data not idle");
  stop_reads_a: assert property (r && ADDR == 4'h7 |=> RDATA == 8'h00)
    else $error("stop register not zero");
  start_upper_a: assert property (r && ADDR == 4'h6 |=> RDATA[7:2] == 0)
    else $error("start register upper bits set");
  start_en_a: assert property (w && ADDR == 4'h6 && WDATA[0] ##1 !WR
    ##1 r && ADDR == 4'h6 |=> RDATA[0]) else $error("start not seen");
  stop_en_a: assert property (w && ADDR == 4'h7 && WDATA[0] ##1 !WR
    ##1 r && ADDR == 4'h6 |=> !RDATA[0]) else $error("stop not seen");
  tout_cause_a: assert property ($changed(TIMER_OUT) |->
    $past(COUNT_TICK) || $past(WR) || $past(WR, 2))
    else $error("timer output moved without cause");
  freeze_all_a: assert property (!e |=> $stable(TIMER_OUT) && $stable(IRQ))
    else $error("outputs moved while frozen");
  irq_mask_a: assert property (w && ADDR == 4'hb && WDATA == 8'h00
    ##1 (e && !(WR && ADDR == 4'hb))[*2] |-> !IRQ)
    else $error("interrupt high with mask clear");
  cover property (w && ADDR == 4'h6);
  cover property ($rose(IRQ));
  cover property ($changed(TIMER_OUT));
endmodule
bind tcit_timer tcit_monitor mon_u (.CLOCK(CLOCK), .RST_N(RST_N),
  .CLK_EN(CLK_EN), .COUNT_TICK(COUNT_TICK), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .TIMER_OUT(TIMER_OUT), .IRQ(IRQ));

//--- tb_tcit_timer.sv
`timescale 1ns/10ps
module tb_tcit_timer;
  logic CLOCK, RST_N, CLK_EN, COUNT_TICK, WR, RD, IRQ;
  logic [1:0] CAPTURE_IN, TIMER_OUT;
  logic [3:0] ADDR;
  logic [7:0] WDATA, RDATA, d, n;
  logic o;
  int errors, total_checks;
  logic [19:0] rows [5] = '{20'h01212, 20'h13434, 20'h25656, 20'h37878,
                            20'h7ff00};
  tcit_timer dut_u (.CLOCK(CLOCK), .RST_N(RST_N), .CLK_EN(CLK_EN),
    .COUNT_TICK(COUNT_TICK), .CAPTURE_IN(CAPTURE_IN), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .TIMER_OUT(TIMER_OUT), .IRQ(IRQ));
  initial begin
    CLOCK = 0;
    forever #25 CLOCK = ~CLOCK;
  end
  task chk(input [7:0] s, input [7:0] x);
    total_checks++;
    if (s !== x) begin
      errors++;
      $display("MISMATCH %0t %h %h", $time, s, x);
    end
  endtask
  task close_out;
    if (errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task wr(input [3:0] a, input [7:0] v);
    @(posedge CLOCK); ADDR <= a; WDATA <= v; WR <= 1;
    @(posedge CLOCK); WR <= 0;
  endtask
  task rd(input [3:0] a);
    @(posedge CLOCK); ADDR <= a; RD <= 1;
    @(posedge CLOCK); RD <= 0;
    @(negedge CLOCK); d = RDATA;
  endtask
  // one count clock tick, then a quiet cycle
  task pulse;
    @(posedge CLOCK); COUNT_TICK <= 1;
    @(posedge CLOCK); COUNT_TICK <= 0;
  endtask
  // one toggle-to-toggle span of channel 0, bounded
  task span;
    o = TIMER_OUT[0];
    n = 0;
    while (TIMER_OUT[0] === o && n < 60) begin
      @(negedge CLOCK); n++;
    end
  endtask
  initial begin
    #100000;
    errors++;
    close_out;
  end
  initial begin
    {RST_N, COUNT_TICK, WR, RD, CAPTURE_IN, ADDR, WDATA} = 0;
    CLK_EN = 1;
    repeat (2) @(posedge CLOCK);
    RST_N <= 1;
    for (int i = 0; i < 4; i++) begin
      rd(i[3:0]); chk(d, 8'hff);
    end
    foreach (rows[i]) begin
      wr(rows[i][19:16], rows[i][15:8]);
      rd(rows[i][19:16]); chk(d, rows[i][7:0]);
    end
    wr(4'h0, 8'h00); wr(4'h1, 8'h03); wr(4'h8, 8'h01); wr(4'hb, 8'h01);
    wr(4'h6, 8'h01);
    rd(4'h6); chk(d & 8'h01, 8'h01);
    chk({6'h0, TIMER_OUT} & 8'h01, 8'h01);
    @(posedge CLOCK) COUNT_TICK <= 1;
    span;
    span; chk(n, 8'h04);
    chk({7'h0, IRQ}, 8'h01);
    rd(4'h5); chk(d & 8'h80, 8'h80);
    @(posedge CLOCK) COUNT_TICK <= 0;
    wr(4'h7, 8'h01);
    rd(4'h6); chk(d & 8'h01, 8'h00);
    rd(4'h5); chk(d & 8'h80, 8'h80);
    wr(4'h5, 8'h00);
    rd(4'h5); chk(d & 8'h80, 8'h00);
    rd(4'ha); wr(4'hb, 8'h00);
    repeat (3) @(negedge CLOCK);
    chk({7'h0, IRQ}, 8'h00);
    wr(4'h2, 8'h00); wr(4'h3, 8'h02); wr(4'h9, 8'h00);
    wr(4'h6, 8'h02);
    rd(4'h4); chk(d & 8'h01, 8'h00);
    chk({6'h0, TIMER_OUT} & 8'h02, 8'h00);
    rd(4'hf); chk(d, 8'h02);
    pulse;
    rd(4'hf); chk(d, 8'h01);
    wr(4'h7, 8'h02);
    wr(4'h9, 8'h08); wr(4'h6, 8'h02); pulse;
    wr(4'h6, 8'h02);
    rd(4'hf); chk(d, 8'h01);
    rd(4'h4); chk(d & 8'h01, 8'h00);
    wr(4'h9, 8'h09); wr(4'h6, 8'h02);
    rd(4'h4); chk(d & 8'h01, 8'h01);
    rd(4'hf); chk(d, 8'h02);
    o = TIMER_OUT[0];
    wr(4'h8, 8'h04); wr(4'h6, 8'h01);
    @(negedge CLOCK);
    chk({7'h0, TIMER_OUT[0]}, {7'h0, o});
    repeat (3) pulse;
    rd(4'he); chk(d, 8'h03);
    @(posedge CLOCK) CAPTURE_IN <= 2'b01;
    pulse;
    rd(4'h5); chk(d & 8'h80, 8'h80);
    rd(4'he); chk(d, 8'h00);
    wr(4'h8, 8'h07); wr(4'h9, 8'h06);
    rd(4'ha); chk(d & 8'h0c, 8'h04);
    wr(4'h8, 8'h00); wr(4'h6, 8'h01);
    @(posedge CLOCK);
    COUNT_TICK <= 1;
    CLK_EN <= 0;
    @(negedge CLOCK) o = TIMER_OUT[0];
    repeat (10) @(negedge CLOCK);
    chk({7'h0, TIMER_OUT[0]}, {7'h0, o});
    @(posedge CLOCK);
    CLK_EN <= 1;
    COUNT_TICK <= 0;
    @(posedge CLOCK) RST_N <= 0;
    @(posedge CLOCK) RST_N <= 1;
    @(negedge CLOCK);
    chk({5'h0, IRQ, TIMER_OUT}, 8'h00);
    rd(4'h5); chk(d, 8'h00);
    rd(4'h0); chk(d, 8'hff);
    close_out;
  end
endmodule
